// >>> ema_alert_ctrl.sv
// Purpose: Error masking, duplicated status banks and alert generation, APB slave
// Assumes: Measured values come from logic on i_sys_clk; pins are synchronised here
// Notes:   Status words hold one event vector split over a low and a high word
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ema_map.svh"
module ema_alert_ctrl #(
  parameter int NV = 16,
  parameter int NT = 4,
  parameter int NF = 4,
  parameter int NG = 8
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_reset_n,
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [7:0]      i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  input  wire logic [NV*8-1:0] i_volt_value,
  input  wire logic [NT*8-1:0] i_temp_value,
  input  wire logic [NT-1:0]   i_diode_fault,
  input  wire logic [NF*8-1:0] i_tach_count,
  input  wire logic [7:0]      i_throttle_level,
  input  wire logic [1:0]      i_processor_throttle_indicator,
  input  wire logic [NG-1:0]   i_general_input,
  input  wire logic [1:0]      i_regulator_overheat_input,
  input  wire logic            i_reset_pin_n,
  output logic                 o_alert,
  output logic                 o_mgmt_side_error_pin,
  output logic                 o_host_error_pin,
  output logic                 o_irq
);
  import ema_pkg::*;

  localparam int EW    = NV + 2 * NT + NF + NG + 2 + 1 + 2;
  localparam int P_TMP = NV;
  localparam int P_DIO = P_TMP + NT;
  localparam int P_TCH = P_DIO + NT;
  localparam int P_GPI = P_TCH + NF;
  localparam int P_VRD = P_GPI + NG;
  localparam int P_USR = P_VRD + 2;
  localparam int P_FIX = P_USR + 1;
  localparam int PINW  = NG + 2 + 1;
  localparam int RST_CYC = (`EMA_RST_DLY_NS * `EMA_CLK_MHZ) / 1000;
  localparam int RCW     = $clog2(RST_CYC + 1);
  // Fixed-threshold throttle bits sit on top and are left out of the alert, both error pins and the interrupt
  localparam logic [EW-1:0] CAPABLE = {2'b00, {(EW - 2){1'b1}}};

  // Refused at elaboration: status words and counters cannot serve these sizes
  if (NV < 1 || NV > 16 || NT < 1 || NT > 8 || NF < 1 || NF > 8) begin
    $error("ema_alert_ctrl: channel count out of range");
  end
  if (NG < 1 || NG > 32 || EW > 63 || RST_CYC < 1) begin
    $error("ema_alert_ctrl: configuration out of range");
  end

  // Value above limit; a limit equal to the mask code never trips
  function automatic logic over_limit(input ema_byte_t val, input ema_byte_t lim,
                                      input ema_byte_t mcode, input logic sgn);
    logic gt;
    gt = sgn ? ($signed(val) > $signed(lim)) : (val > lim);
    return gt && (lim != mcode);
  endfunction

  function automatic logic [31:0] word_of(input logic [EW-1:0] v, input logic hi);
    logic [63:0] w;
    w = {{(64 - EW){1'b0}}, v};
    return hi ? w[63:32] : w[31:0];
  endfunction

  // Pin synchronisers
  logic [PINW-1:0] pin_meta_reg;
  logic [PINW-1:0] pin_sync_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pin_meta_reg <= {1'b1, {(PINW - 1){1'b0}}};
      pin_sync_reg <= {1'b1, {(PINW - 1){1'b0}}};
    end else begin
      pin_meta_reg <= {i_reset_pin_n, i_regulator_overheat_input, i_general_input};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic [NG-1:0] gpi_s;
  logic [1:0]    vrd_s;
  logic          rst_pin_n_s;
  assign gpi_s       = pin_sync_reg[NG-1:0];
  assign vrd_s       = pin_sync_reg[NG+1:NG];
  assign rst_pin_n_s = pin_sync_reg[NG+2];

  // Registers
  logic [31:0]     cfg_reg;
  ema_sleep_t      sleep_reg;
  logic [5:0]      sleep_mask_reg;
  logic [NG-1:0]   gpi_mask_reg;
  logic [1:0]      misc_mask_reg;
  ema_byte_t       user_lim_reg;
  logic [2:0]      irq_stat_reg;
  logic [2:0]      irq_mask_reg;
  ema_byte_t       volt_lim_reg [NV];
  ema_byte_t       temp_lim_reg [NT];
  ema_byte_t       tach_lim_reg [NF];

  // APB handshake: one wait cycle, write and read side effects at the pready edge
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic [5:0]  widx;
  logic        locked;

  assign acc    = i_psel && i_penable && o_pready;
  assign wr     = acc && i_pwrite;
  assign rd     = acc && !i_pwrite;
  assign widx   = i_paddr[7:2];
  assign locked = cfg_reg[`EMA_CFG_LOCK];

  logic [EW-1:0] host_st;
  logic [EW-1:0] mgmt_st;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (i_paddr)
      `EMA_OFF_CFG:        rd_data = cfg_reg;
      `EMA_OFF_SLEEP:      rd_data = {30'h0000_0000, sleep_reg};
      `EMA_OFF_SLEEP_MASK: rd_data = {26'h000_0000, sleep_mask_reg};
      `EMA_OFF_GPI_MASK:   rd_data = 32'(gpi_mask_reg);
      `EMA_OFF_MISC_MASK:  rd_data = {30'h0000_0000, misc_mask_reg};
      `EMA_OFF_USER_LIM:   rd_data = {24'h00_0000, user_lim_reg};
      `EMA_OFF_IRQ_STAT:   rd_data = {29'h0000_0000, irq_stat_reg};
      `EMA_OFF_IRQ_MASK:   rd_data = {29'h0000_0000, irq_mask_reg};
      `EMA_OFF_HOST_ST0:   rd_data = word_of(host_st, 1'b0);
      `EMA_OFF_HOST_ST1:   rd_data = word_of(host_st, 1'b1);
      `EMA_OFF_MGMT_ST0:   rd_data = word_of(mgmt_st, 1'b0);
      `EMA_OFF_MGMT_ST1:   rd_data = word_of(mgmt_st, 1'b1);
      default: begin
        if (i_paddr[1:0] == 2'h0 && i_paddr >= `EMA_OFF_VOLT_LIM &&
            int'(widx) < int'(`EMA_OFF_VOLT_LIM >> 2) + NV) begin
          rd_data = {24'h00_0000, volt_lim_reg[int'(widx) - int'(`EMA_OFF_VOLT_LIM >> 2)]};
        end else if (i_paddr[1:0] == 2'h0 && i_paddr >= `EMA_OFF_TEMP_LIM &&
                     int'(widx) < int'(`EMA_OFF_TEMP_LIM >> 2) + NT) begin
          rd_data = {24'h00_0000, temp_lim_reg[int'(widx) - int'(`EMA_OFF_TEMP_LIM >> 2)]};
        end else if (i_paddr[1:0] == 2'h0 && i_paddr >= `EMA_OFF_TACH_LIM &&
                     int'(widx) < int'(`EMA_OFF_TACH_LIM >> 2) + NF) begin
          rd_data = {24'h00_0000, tach_lim_reg[int'(widx) - int'(`EMA_OFF_TACH_LIM >> 2)]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      // Error only stands beside pready, never after it
      o_pslverr <= i_psel && i_penable && !o_pready && !rd_hit;
      if (i_psel && i_penable && !o_pready) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // Reset pin timer
  ema_rst_state_t rst_state_reg;
  logic [RCW-1:0] rst_cnt_reg;
  logic           rst_fire;

  assign rst_fire = (rst_state_reg == RST_WAIT) && (int'(rst_cnt_reg) == RST_CYC - 1);

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rst_state_reg <= RST_IDLE;
      rst_cnt_reg   <= '0;
    end else begin
      case (rst_state_reg)
        RST_IDLE: begin
          rst_cnt_reg <= '0;
          if (!rst_pin_n_s) rst_state_reg <= RST_WAIT;
        end
        RST_WAIT: begin
          if (rst_pin_n_s) begin
            rst_state_reg <= RST_IDLE;
          end else if (rst_fire) begin
            rst_state_reg <= RST_DONE;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + RCW'(1);
          end
        end
        RST_DONE: begin
          if (rst_pin_n_s) rst_state_reg <= RST_IDLE;
        end
        default: rst_state_reg <= RST_IDLE;
      endcase
    end
  end

  // Configuration and sleep control; lock only protects limits and masks
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      cfg_reg   <= `EMA_RST_CFG;
      sleep_reg <= `EMA_SLEEP_S45;
    end else begin
      if (wr && i_paddr == `EMA_OFF_CFG) begin
        cfg_reg <= {29'h0000_0000, i_pwdata[`EMA_CFG_ASF],
                    i_pwdata[`EMA_CFG_LOCK] | locked, i_pwdata[`EMA_CFG_ALERT_EN]};
      end
      if (wr && i_paddr == `EMA_OFF_SLEEP) sleep_reg <= i_pwdata[1:0];
      if (rst_fire) begin
        cfg_reg[`EMA_CFG_LOCK] <= 1'b0;
        sleep_reg              <= `EMA_SLEEP_S45;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      sleep_mask_reg <= 6'(`EMA_RST_MASK);
      gpi_mask_reg   <= NG'(`EMA_RST_MASK);
      misc_mask_reg  <= 2'(`EMA_RST_MASK);
      user_lim_reg   <= `EMA_USER_MASK_VAL;
      irq_mask_reg   <= 3'(`EMA_RST_MASK);
    end else if (wr && !locked) begin
      case (i_paddr)
        `EMA_OFF_SLEEP_MASK: sleep_mask_reg <= i_pwdata[5:0];
        `EMA_OFF_GPI_MASK:   gpi_mask_reg   <= i_pwdata[NG-1:0];
        `EMA_OFF_MISC_MASK:  misc_mask_reg  <= i_pwdata[1:0];
        `EMA_OFF_USER_LIM:   user_lim_reg   <= i_pwdata[7:0];
        `EMA_OFF_IRQ_MASK:   irq_mask_reg   <= i_pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NV; i++) volt_lim_reg[i] <= `EMA_VOLT_MASK_VAL;
      for (int i = 0; i < NT; i++) temp_lim_reg[i] <= `EMA_TEMP_MASK_VAL;
      for (int i = 0; i < NF; i++) tach_lim_reg[i] <= `EMA_TACH_MASK_VAL;
    end else if (wr && !locked) begin
      for (int i = 0; i < NV; i++) begin
        if (i_paddr == 8'(`EMA_OFF_VOLT_LIM + 4 * i)) volt_lim_reg[i] <= i_pwdata[7:0];
      end
      for (int i = 0; i < NT; i++) begin
        if (i_paddr == 8'(`EMA_OFF_TEMP_LIM + 4 * i)) temp_lim_reg[i] <= i_pwdata[7:0];
      end
      for (int i = 0; i < NF; i++) begin
        if (i_paddr == 8'(`EMA_OFF_TACH_LIM + 4 * i)) tach_lim_reg[i] <= i_pwdata[7:0];
      end
    end
  end

  // Event qualification
  logic [EW-1:0] raw_ev;
  logic [EW-1:0] sleep_kill;
  logic [EW-1:0] set_ev;
  logic          in_sleep;
  logic          deep;

  assign in_sleep = (sleep_reg != `EMA_SLEEP_S0);
  assign deep     = (sleep_reg == `EMA_SLEEP_S3) || (sleep_reg == `EMA_SLEEP_S45);

  always_comb begin
    raw_ev = '0;
    for (int i = 0; i < NV; i++) begin
      raw_ev[i] = over_limit(i_volt_value[i*8 +: 8], volt_lim_reg[i],
                             `EMA_VOLT_MASK_VAL, 1'b0);
    end
    for (int i = 0; i < NT; i++) begin
      raw_ev[P_TMP+i] = over_limit(i_temp_value[i*8 +: 8], temp_lim_reg[i],
                                   `EMA_TEMP_MASK_VAL, 1'b1);
      raw_ev[P_DIO+i] = i_diode_fault[i] &&
                        (temp_lim_reg[i] != `EMA_TEMP_MASK_VAL);
    end
    for (int i = 0; i < NF; i++) begin
      raw_ev[P_TCH+i] = over_limit(i_tach_count[i*8 +: 8], tach_lim_reg[i],
                                   `EMA_TACH_MASK_VAL, 1'b0);
    end
    raw_ev[P_GPI +: NG] = gpi_s & ~gpi_mask_reg;
    raw_ev[P_VRD +: 2]  = vrd_s & ~misc_mask_reg;
    raw_ev[P_USR] = over_limit(i_throttle_level, user_lim_reg,
                               `EMA_USER_MASK_VAL, 1'b0);
    raw_ev[P_FIX +: 2] = i_processor_throttle_indicator;
  end

  // Rails and fans are off in S3 and S4/S5, temperatures too in S4/S5
  always_comb begin
    sleep_kill = '0;
    sleep_kill[NV-1:0]    = {NV{deep}};
    sleep_kill[P_TCH +: NF] = {NF{deep}};
    sleep_kill[P_TMP +: NT] = {NT{sleep_reg == `EMA_SLEEP_S45}};
    sleep_kill[P_DIO +: NT] = {NT{sleep_reg == `EMA_SLEEP_S45}};
    if (in_sleep) begin
      sleep_kill[NV-1:0]      = sleep_kill[NV-1:0]    | {NV{sleep_mask_reg[`EMA_SLM_VOLT]}};
      sleep_kill[P_TMP +: NT] = sleep_kill[P_TMP +: NT] | {NT{sleep_mask_reg[`EMA_SLM_TEMP]}};
      sleep_kill[P_DIO +: NT] = sleep_kill[P_DIO +: NT] | {NT{sleep_mask_reg[`EMA_SLM_TEMP]}};
      sleep_kill[P_TCH +: NF] = sleep_kill[P_TCH +: NF] | {NF{sleep_mask_reg[`EMA_SLM_TACH]}};
      sleep_kill[P_GPI +: NG] = {NG{sleep_mask_reg[`EMA_SLM_GPI]}};
      sleep_kill[P_VRD +: 2]  = {2{sleep_mask_reg[`EMA_SLM_VRD]}};
      sleep_kill[P_USR]       = sleep_mask_reg[`EMA_SLM_USER];
    end
    sleep_kill[P_FIX +: 2] = 2'b00;
  end

  assign set_ev = raw_ev & ~sleep_kill;

  // Clear vectors, one per bank, built only from that bank's own address
  logic [63:0] wmask;
  logic [EW-1:0] host_clr;
  logic [EW-1:0] mgmt_clr;

  always_comb begin
    wmask = 64'h0;
    if (wr && i_paddr == `EMA_OFF_HOST_ST0) wmask[31:0]  = i_pwdata;
    if (wr && i_paddr == `EMA_OFF_HOST_ST1) wmask[63:32] = i_pwdata;
    host_clr = wmask[EW-1:0];
    wmask = 64'h0;
    if (wr && i_paddr == `EMA_OFF_MGMT_ST0) wmask[31:0]  = i_pwdata;
    if (wr && i_paddr == `EMA_OFF_MGMT_ST1) wmask[63:32] = i_pwdata;
    if (rd && cfg_reg[`EMA_CFG_ASF] && i_paddr == `EMA_OFF_MGMT_ST0) begin
      wmask[31:0] = 32'hffff_ffff;
    end
    if (rd && cfg_reg[`EMA_CFG_ASF] && i_paddr == `EMA_OFF_MGMT_ST1) begin
      wmask[63:32] = 32'hffff_ffff;
    end
    mgmt_clr = wmask[EW-1:0];
  end

  ema_bank_if #(.W(EW)) host_if ();
  ema_bank_if #(.W(EW)) mgmt_if ();

  assign host_if.set_vec = set_ev;
  assign host_if.clr_vec = host_clr;
  assign mgmt_if.set_vec = set_ev;
  assign mgmt_if.clr_vec = mgmt_clr;
  assign host_st         = host_if.status;
  assign mgmt_st         = mgmt_if.status;

  ema_err_bank #(.W(EW)) u_host_bank (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .bus       (host_if.bank)
  );

  ema_err_bank #(.W(EW)) u_mgmt_bank (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .bus       (mgmt_if.bank)
  );

  // Interrupt status: sticky, read clears, a new event in the read cycle survives
  logic [2:0] irq_set;
  logic       irq_rd;
  assign irq_set = {rst_fire, |(set_ev & CAPABLE & ~mgmt_st), |(set_ev & CAPABLE & ~host_st)};
  assign irq_rd  = rd && i_paddr == `EMA_OFF_IRQ_STAT;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_rd ? 3'h0 : irq_stat_reg) | irq_set;
    end
  end

  // Outputs lag the status banks by one cycle so they come straight from flip-flops
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_alert               <= 1'b0;
      o_host_error_pin      <= 1'b0;
      o_mgmt_side_error_pin <= 1'b0;
      o_irq                 <= 1'b0;
    end else begin
      o_alert <= cfg_reg[`EMA_CFG_ALERT_EN] && |(host_st & CAPABLE);
      o_host_error_pin      <= |(host_st & CAPABLE);
      o_mgmt_side_error_pin <= |(mgmt_st & CAPABLE);
      o_irq                 <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// >>> ema_map.svh
// Purpose: Offsets, field positions, reset values and timing for the error mask/alert block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef EMA_MAP_SVH
`define EMA_MAP_SVH

`define EMA_OFF_CFG        8'h00
`define EMA_OFF_SLEEP      8'h04
`define EMA_OFF_SLEEP_MASK 8'h08
`define EMA_OFF_GPI_MASK   8'h0c
`define EMA_OFF_MISC_MASK  8'h10
`define EMA_OFF_USER_LIM   8'h14
`define EMA_OFF_IRQ_STAT   8'h18
`define EMA_OFF_IRQ_MASK   8'h1c
`define EMA_OFF_HOST_ST0   8'h20
`define EMA_OFF_HOST_ST1   8'h24
`define EMA_OFF_MGMT_ST0   8'h28
`define EMA_OFF_MGMT_ST1   8'h2c
`define EMA_OFF_VOLT_LIM   8'h40
`define EMA_OFF_TEMP_LIM   8'h80
`define EMA_OFF_TACH_LIM   8'ha0

`define EMA_CFG_ALERT_EN   0
`define EMA_CFG_LOCK       1
`define EMA_CFG_ASF        2

`define EMA_SLM_VOLT       0
`define EMA_SLM_TEMP       1
`define EMA_SLM_TACH       2
`define EMA_SLM_GPI        3
`define EMA_SLM_VRD        4
`define EMA_SLM_USER       5

`define EMA_IRQ_HOST_NEW   0
`define EMA_IRQ_MGMT_NEW   1
`define EMA_IRQ_PIN_RESET  2

`define EMA_SLEEP_S0       2'h0
`define EMA_SLEEP_S1       2'h1
`define EMA_SLEEP_S3       2'h2
`define EMA_SLEEP_S45      2'h3

`define EMA_VOLT_MASK_VAL  8'hff
`define EMA_TEMP_MASK_VAL  8'h80
`define EMA_TACH_MASK_VAL  8'hff
`define EMA_USER_MASK_VAL  8'hff

`define EMA_RST_CFG        32'h0000_0000
`define EMA_RST_MASK       32'h0000_0000

`define EMA_CLK_MHZ        10
`define EMA_RST_DLY_NS     10000

`endif

// >>> ema_pkg.sv
// Purpose: Shared types of the error mask/alert block
// Assumes: Constants live in ema_map.svh
// Notes:   Types only
package ema_pkg;
  typedef logic [1:0]  ema_sleep_t;
  typedef logic [7:0]  ema_byte_t;
  typedef enum logic [1:0] {RST_IDLE, RST_WAIT, RST_DONE} ema_rst_state_t;
endpackage

// >>> ema_bank_if.sv
// Purpose: Carries set/clear vectors and status between the top and one status bank
// Assumes: Single clock domain
// Notes:   ctrl is the top side, bank is the status bank side
`timescale 1ns/100ps
`default_nettype none
interface ema_bank_if #(parameter int W = 41);
  logic [W-1:0] set_vec;
  logic [W-1:0] clr_vec;
  logic [W-1:0] status;
  modport ctrl (output set_vec, output clr_vec, input status);
  modport bank (input set_vec, input clr_vec, output status);
endinterface
`default_nettype wire

// >>> ema_err_bank.sv
// Purpose: One sticky error status bank (host side or management side)
// Assumes: Set and clear vectors already qualified by the top
// Notes:   Set wins over clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "ema_map.svh"
module ema_err_bank #(
  parameter int W = 41
) (
  input  wire logic  i_sys_clk,
  input  wire logic  i_reset_n,
  ema_bank_if.bank   bus
);
  import ema_pkg::*;

  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;

  if (W < 1 || W > 63) begin
    $error("ema_err_bank: width out of range");
  end

  // A masked event never reaches set_vec, and masking alone never clears
  // Clear only drops a bit whose event is gone this cycle; a live event re-sets it
  always_comb begin
    status_next = (status_reg & ~bus.clr_vec) | bus.set_vec;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign bus.status = status_reg;
endmodule
`default_nettype wire

// >>> ema_alert_ctrl_props.sv
// Purpose: Port-level checks of the error mask/alert block
// Assumes: Byte offsets of the register map, one APB word each
// Notes:   Bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module ema_alert_ctrl_props (
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_alert,
  input wire logic        o_host_error_pin,
  input wire logic        o_mgmt_side_error_pin
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic acc;
  logic en_seen_reg;
  logic hclr;
  logic mclr;
  logic cfg_wr;
  assign acc    = i_psel && i_penable && o_pready;
  // Pins fall two edges after the access: bank flop, then pin flop
  assign hclr   = acc && i_pwrite && i_paddr[7:3] == 5'h04;
  assign mclr   = acc && i_paddr[7:3] == 5'h05;
  assign cfg_wr = acc && i_pwrite && i_paddr == 8'h00;
  // Alert may only appear once software has enabled it at least once
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n)
      en_seen_reg <= 1'b0;
    else if (acc && i_pwrite && i_paddr == 8'h00 && i_pwdata[0])
      en_seen_reg <= 1'b1;
  end
  sequence setup_s; i_psel && !i_penable; endsequence
  sequence access_s; i_psel && i_penable; endsequence
  apb_answer_a: assert property (setup_s ##1 access_s |-> !o_pready ##1 o_pready)
    else $error("pready not on second access cycle");
  slverr_pair_a: assert property (o_pslverr |-> o_pready && i_psel && i_penable)
    else $error("pslverr outside an answer");
  alert_pin_a: assert property (o_alert |-> o_host_error_pin)
    else $error("alert without host error");
  alert_boot_a: assert property (!en_seen_reg |-> !o_alert)
    else $error("alert before enable");
  host_hold_a: assert property ($fell(o_host_error_pin) |->
    $past(hclr, 2)) else $error("host error fell alone");
  mgmt_hold_a: assert property ($fell(o_mgmt_side_error_pin) |->
    $past(mclr, 2)) else $error("mgmt error fell alone");
  alert_fall_a: assert property ($fell(o_alert) |-> $fell(o_host_error_pin) ||
    $past(cfg_wr, 2)) else $error("alert fell alone");
  banks_pair_a: assert property ($rose(o_host_error_pin) |-> o_mgmt_side_error_pin)
    else $error("host bank set without mgmt bank");
endmodule
bind ema_alert_ctrl ema_alert_ctrl_props i_props (.i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_alert(o_alert), .o_host_error_pin(o_host_error_pin),
  .o_mgmt_side_error_pin(o_mgmt_side_error_pin));
`default_nettype wire

// >>> ema_host_model.sv
// Purpose: Software side on the register bus
// Assumes: Slave answer time unknown; waits for pready
// Notes:   Hangs are cut by the bench watchdog
`timescale 1ns/100ps
`default_nettype none
module ema_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output var  logic        o_psel,
  output var  logic        o_penable,
  output var  logic        o_pwrite,
  output var  logic [7:0]  o_paddr,
  output var  logic [31:0] o_pwdata
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_sys_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    // Request held until pready is sampled high
    do @(posedge i_sys_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the error mask/alert block
// Assumes: Inputs change at the rising edge by non-blocking assignment
// Notes:   Status word 1 holds event bits 40:32
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [127:0] volt = '0;
  logic [31:0] temp = '0, tach = '0;
  logic [7:0] thr = '0, general_input = '0;
  logic [3:0] dio = '0;
  logic [1:0] pt = '0, vrd = '0;
  logic rpin_n = 1'b1;
  wire [31:0] prdata, pwdata;
  wire [7:0] paddr;
  wire pready, pslverr, psel, penable, pwrite, alert, herr, merr, irq;
  wire [31:0] pins = {28'h0, alert, herr, merr, irq};
  int n_fail = 0;
  int tests_run = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  ema_alert_ctrl i_ema_alert_ctrl (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_volt_value(volt), .i_temp_value(temp), .i_diode_fault(dio), .i_tach_count(tach),
    .i_throttle_level(thr), .i_processor_throttle_indicator(pt), .i_general_input(general_input),
    .i_regulator_overheat_input(vrd), .i_reset_pin_n(rpin_n), .o_alert(alert),
    .o_mgmt_side_error_pin(merr), .o_host_error_pin(herr), .o_irq(irq));
  ema_host_model i_ema_host_model (.i_sys_clk(i_sys_clk), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    i_ema_host_model.xfer(1'b1, a, d, q, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic er;
    i_ema_host_model.xfer(1'b0, a, 32'h0, q, er);
    chk(q, e);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    logic er;
    rd(8'h40, 32'hff);
    rd(8'h8c, 32'h80);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h3);
    i_ema_host_model.xfer(1'b0, 8'h3c, 32'h0, q, er);
    chk({31'h0, er}, 32'h1);
    chk(pins, 32'h0);
  endtask
  task automatic t_limits;
    wr(8'h04, 32'h0);
    volt <= '1;
    temp <= {4{8'h7f}};
    dio <= 4'hf;
    tach <= '1;
    thr <= 8'hff;
    cyc(6);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    wr(8'h80, 32'h10);
    cyc(4);
    rd(8'h28, 32'h0011_0000);
    temp <= '0;
    dio <= '0;
    wr(8'h80, 32'h80);
    wr(8'h20, 32'h0011_0000);
    wr(8'h28, 32'h0011_0000);
  endtask
  task automatic t_w1c;
    general_input <= 8'h01;
    cyc(6);
    rd(8'h20, 32'h1000_0000);
    wr(8'h20, 32'h1000_0000);
    rd(8'h20, 32'h1000_0000);
    general_input <= 8'h00;
    cyc(6);
    wr(8'h20, 32'h1000_0000);
    rd(8'h20, 32'h0);
    rd(8'h28, 32'h1000_0000);
    chk(pins, 32'h2);
    wr(8'h28, 32'h1000_0000);
  endtask
  task automatic t_mask;
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h2);
    general_input <= 8'h02;
    vrd <= 2'b01;
    cyc(6);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h10);
    chk(pins, 32'he);
    wr(8'h10, 32'h1);
    rd(8'h24, 32'h10);
    wr(8'h24, 32'h10);
    wr(8'h2c, 32'h10);
    rd(8'h24, 32'h0);
    chk(pins, 32'h0);
    general_input <= 8'h00;
    vrd <= 2'b00;
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_fixed;
    pt <= 2'b11;
    cyc(6);
    rd(8'h24, 32'h180);
    chk(pins, 32'h0);
    pt <= 2'b00;
    wr(8'h24, 32'h180);
    wr(8'h2c, 32'h180);
  endtask
  task automatic t_sleep;
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h8);
    general_input <= 8'h01;
    cyc(6);
    rd(8'h20, 32'h0);
    general_input <= 8'h00;
    wr(8'h04, 32'h2);
    wr(8'h40, 32'h10);
    cyc(3);
    rd(8'h20, 32'h0);
    wr(8'h04, 32'h0);
    cyc(3);
    rd(8'h20, 32'h1);
  endtask
  task automatic t_asf;
    wr(8'h40, 32'hff);
    wr(8'h00, 32'h5);
    rd(8'h28, 32'h1);
    rd(8'h28, 32'h0);
    rd(8'h20, 32'h1);
    wr(8'h20, 32'h1);
  endtask
  task automatic t_pin;
    logic [31:0] q;
    logic er;
    wr(8'h1c, 32'h4);
    wr(8'h00, 32'h2);
    wr(8'h40, 32'h20);
    rd(8'h40, 32'hff);
    rpin_n <= 1'b0;
    cyc(94);
    rd(8'h00, 32'h2);
    cyc(10);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h3);
    chk(pins, 32'h1);
    rpin_n <= 1'b1;
    i_ema_host_model.xfer(1'b0, 8'h18, 32'h0, q, er);
    chk({31'h0, q[2]}, 32'h1);
    cyc(2);
    chk(pins, 32'h0);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // About 400 cycles of work; a generous margin guards against a hang
  initial begin
    #(3000 * 100);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_reset;
    t_limits;
    t_w1c;
    t_mask;
    t_fixed;
    t_sleep;
    t_asf;
    t_pin;
    report_and_stop;
  end
endmodule
`default_nettype wire
